// ### logic/afc_axis_fault_checker.sv
// Notes on behaviour
// RULE_01 - Command, read-back or preset beyond clockwise limit raises fault 0043.
// RULE_02 - Same checks beyond counter-clockwise limit raise fault 0044.
// RULE_03 - Limit faults: deceleration stop before motion, accumulated-pulse stop after.
// RULE_04 - Movement without established origin is rejected, fault 0045, deceleration stop.
// RULE_05 - With incremental encoder the host runs origin search before moving.
// RULE_06 - With absolute encoder a servo-lock operation establishes the origin.
// RULE_07 - Program or manual command without servo lock: fault 0046, deceleration.
// RULE_08 - Out-of-range present-position preset raises fault 0047, deceleration stop.
// RULE_09 - Emergency stop asserting, or motion with it asserted, raises fault 0048.
// RULE_10 - No absolute encoder data raises fault 0049 with deceleration stop.
// RULE_11 - Communication error during absolute data reception also raises fault 0049.
// RULE_12 - Selectable stop method follows the stop-select system parameter.
// RULE_13 - Fault code stays latched until the host issues an error reset.
`timescale 1ns/100ps
module afc_axis_fault_checker #(
  parameter int unsigned ABS_TIMEOUT_CYC = afc_pkg::ABS_TIMEOUT_CYC
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic CMD_VALID_I,
  input wire logic [2:0] CMD_KIND_I,
  input wire logic signed [31:0] CMD_VALUE_I,
  input wire logic signed [31:0] CW_LIMIT_I,
  input wire logic signed [31:0] CCW_LIMIT_I,
  input wire logic signed [31:0] PRESET_MIN_I,
  input wire logic signed [31:0] PRESET_MAX_I,
  input wire logic MOTION_ACTIVE_I,
  input wire logic SERVO_LOCK_I,
  input wire logic ENC_ABSOLUTE_I,
  input wire logic ORIGIN_SEARCH_DONE_I,
  input wire logic ESTOP_I,
  input wire logic STOP_SEL_EMERG_I,
  input wire logic ABS_REQ_I,
  input wire logic ABS_DATA_VALID_I,
  input wire logic signed [31:0] ABS_POS_I,
  input wire logic ABS_COMM_ERR_I,
  input wire logic ERR_RESET_I,
  output logic FAULT_O,
  output logic [15:0] FAULT_CODE_O,
  output logic [1:0] STOP_METHOD_O,
  output logic STOP_REQ_O,
  output logic CMD_ACCEPT_O,
  output logic CMD_REJECT_O,
  output logic ORIGIN_OK_O,
  output logic ABS_WAIT_O
);

  typedef struct packed {
    afc_pkg::afc_state_t st;
    logic [15:0] code;
    afc_pkg::afc_stop_t stop;
    logic stop_req;
    logic accept;
    logic reject;
    logic origin_ok;
    logic lock_prev;
    logic estop_prev;
  } afc_main_t;

  afc_main_t cur;
  afc_main_t next_cur;
  logic abs_fault;
  logic is_move;
  logic is_motion;
  logic cw_over;
  logic ccw_over;
  logic hit;
  logic [15:0] hit_code;
  afc_pkg::afc_stop_t hit_stop;
  afc_pkg::afc_stop_t limit_stop;
  logic clear_now;

  afc_abs_watch #(
    .TIMEOUT_CYC(ABS_TIMEOUT_CYC)
  ) u_abs_watch (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .req_i(ABS_REQ_I),
    .data_valid_i(ABS_DATA_VALID_I),
    .comm_err_i(ABS_COMM_ERR_I),
    .waiting_o(ABS_WAIT_O),
    .fault_o(abs_fault)
  );

  always_comb
  begin
    is_move = CMD_VALID_I && (CMD_KIND_I == afc_pkg::CMD_MOVE
      || CMD_KIND_I == afc_pkg::CMD_MANUAL);
    is_motion = CMD_VALID_I && CMD_KIND_I != afc_pkg::CMD_PRESET;
    // Read-back and a coincident host command are both held to the limits,
    // so a command arriving with encoder data is never waved through
    cw_over = (ABS_DATA_VALID_I && ABS_POS_I > CW_LIMIT_I)
      || (CMD_VALID_I && CMD_VALUE_I > CW_LIMIT_I);
    ccw_over = (ABS_DATA_VALID_I && ABS_POS_I < CCW_LIMIT_I)
      || (CMD_VALID_I && CMD_VALUE_I < CCW_LIMIT_I);
    limit_stop = MOTION_ACTIVE_I ? afc_pkg::STOP_ACCUM : afc_pkg::STOP_DECEL; // [RULE_03]
    hit = 1'b1;
    hit_code = afc_pkg::CODE_NONE;
    hit_stop = afc_pkg::STOP_DECEL;
    if ((ESTOP_I && !cur.estop_prev) || (is_motion && ESTOP_I))
    begin
      hit_code = afc_pkg::CODE_ESTOP; // [RULE_09]
      hit_stop = STOP_SEL_EMERG_I ? afc_pkg::STOP_EMERG : afc_pkg::STOP_ACCUM; // [RULE_12]
    end
    else if (abs_fault)
    begin
      hit_code = afc_pkg::CODE_ABS_LINK; // [RULE_10] [RULE_11]
    end
    else if (is_motion && !SERVO_LOCK_I)
    begin
      hit_code = afc_pkg::CODE_SERVO; // [RULE_07]
    end
    else if (is_move && !cur.origin_ok)
    begin
      hit_code = afc_pkg::CODE_ORIGIN; // [RULE_04]
    end
    else if (CMD_VALID_I && CMD_KIND_I == afc_pkg::CMD_PRESET
      && (CMD_VALUE_I < PRESET_MIN_I || CMD_VALUE_I > PRESET_MAX_I))
    begin
      hit_code = afc_pkg::CODE_PRESET; // [RULE_08]
    end
    else if (cw_over)
    begin
      hit_code = afc_pkg::CODE_CW_SOFT; // [RULE_01]
      hit_stop = limit_stop;
    end
    else if (ccw_over)
    begin
      hit_code = afc_pkg::CODE_CCW_SOFT; // [RULE_02]
      hit_stop = limit_stop;
    end
    else
    begin
      hit = 1'b0;
    end
  end

  always_comb
  begin
    next_cur = cur;
    next_cur.stop_req = 1'b0;
    next_cur.accept = 1'b0;
    next_cur.reject = 1'b0;
    next_cur.estop_prev = ESTOP_I;
    next_cur.lock_prev = SERVO_LOCK_I;
    // Origin comes from a finished search or a fresh servo-lock edge
    if (!ENC_ABSOLUTE_I && ORIGIN_SEARCH_DONE_I)
    begin
      next_cur.origin_ok = 1'b1; // [RULE_05]
    end
    if (ENC_ABSOLUTE_I && SERVO_LOCK_I && !cur.lock_prev)
    begin
      next_cur.origin_ok = 1'b1; // [RULE_06]
    end
    // A new fault in the reset cycle is latched, so the set wins
    clear_now = (cur.st == afc_pkg::ST_CLEAR) || ERR_RESET_I;
    if (ERR_RESET_I)
    begin
      next_cur.st = afc_pkg::ST_CLEAR;
      next_cur.code = afc_pkg::CODE_NONE;
      next_cur.stop = afc_pkg::STOP_NONE;
    end
    if (hit && clear_now)
    begin
      next_cur.st = afc_pkg::ST_FAULT; // [RULE_13]
      next_cur.code = hit_code;
      next_cur.stop = hit_stop;
      next_cur.stop_req = 1'b1;
      next_cur.reject = CMD_VALID_I;
    end
    else if (CMD_VALID_I)
    begin
      // While a fault stands every command is refused, except in the error-reset cycle
      next_cur.accept = clear_now;
      next_cur.reject = !clear_now;
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      cur <= '{st: afc_pkg::ST_CLEAR, code: afc_pkg::CODE_NONE,
        stop: afc_pkg::STOP_NONE, default: 1'b0};
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign FAULT_O = (cur.st == afc_pkg::ST_FAULT);
  assign FAULT_CODE_O = cur.code;
  assign STOP_METHOD_O = cur.stop;
  assign STOP_REQ_O = cur.stop_req;
  assign CMD_ACCEPT_O = cur.accept;
  assign CMD_REJECT_O = cur.reject;
  assign ORIGIN_OK_O = cur.origin_ok;

  default clocking afc_cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);

  chk_cw_limit_cause: assert property ( // [RULE_01]
    STOP_REQ_O && FAULT_CODE_O == afc_pkg::CODE_CW_SOFT
    |-> ($past(ABS_DATA_VALID_I) && $past(ABS_POS_I) > $past(CW_LIMIT_I))
      || ($past(CMD_VALID_I) && $past(CMD_VALUE_I) > $past(CW_LIMIT_I)))
    else $error("clockwise limit fault without a value past the limit");

  chk_ccw_limit_cause: assert property ( // [RULE_02]
    STOP_REQ_O && FAULT_CODE_O == afc_pkg::CODE_CCW_SOFT
    |-> ($past(ABS_DATA_VALID_I) && $past(ABS_POS_I) < $past(CCW_LIMIT_I))
      || ($past(CMD_VALID_I) && $past(CMD_VALUE_I) < $past(CCW_LIMIT_I)))
    else $error("counter-clockwise limit fault without a value past the limit");

  chk_limit_stop_kind: assert property ( // [RULE_03]
    STOP_REQ_O && (FAULT_CODE_O == afc_pkg::CODE_CW_SOFT
      || FAULT_CODE_O == afc_pkg::CODE_CCW_SOFT)
    |-> STOP_METHOD_O == ($past(MOTION_ACTIVE_I) ? afc_pkg::STOP_ACCUM : afc_pkg::STOP_DECEL))
    else $error("limit fault stop method does not follow motion state");

  chk_origin_reject: assert property ( // [RULE_04]
    !FAULT_O && CMD_VALID_I && CMD_KIND_I == afc_pkg::CMD_MOVE && !ORIGIN_OK_O
      && SERVO_LOCK_I && !ESTOP_I && !abs_fault
    |=> CMD_REJECT_O && FAULT_CODE_O == afc_pkg::CODE_ORIGIN
      && STOP_METHOD_O == afc_pkg::STOP_DECEL)
    else $error("move without origin was not refused");

  chk_servo_reject: assert property ( // [RULE_07]
    STOP_REQ_O && FAULT_CODE_O == afc_pkg::CODE_SERVO
    |-> !$past(SERVO_LOCK_I) && $past(CMD_VALID_I) && CMD_REJECT_O)
    else $error("servo lock fault without an unlocked command");

  chk_preset_range: assert property ( // [RULE_08]
    !FAULT_O && CMD_VALID_I && CMD_KIND_I == afc_pkg::CMD_PRESET && !ESTOP_I
      && !abs_fault && CMD_VALUE_I > PRESET_MAX_I
    |=> FAULT_O && FAULT_CODE_O == afc_pkg::CODE_PRESET ##1 !STOP_REQ_O)
    else $error("out-of-range preset was not faulted");

  chk_estop_edge: assert property ( // [RULE_09]
    !FAULT_O && $rose(ESTOP_I)
    |=> FAULT_CODE_O == afc_pkg::CODE_ESTOP
      && STOP_METHOD_O == ($past(STOP_SEL_EMERG_I) ? afc_pkg::STOP_EMERG : afc_pkg::STOP_ACCUM))
    else $error("emergency stop edge did not raise its fault");

  chk_abs_link: assert property ( // [RULE_10]
    !FAULT_O && abs_fault && !ESTOP_I
    |=> FAULT_CODE_O == afc_pkg::CODE_ABS_LINK && STOP_METHOD_O == afc_pkg::STOP_DECEL)
    else $error("encoder link fault not latched");

  chk_fault_hold: assert property ( // [RULE_13]
    FAULT_O && !ERR_RESET_I |=> FAULT_O && $stable(FAULT_CODE_O))
    else $error("fault code changed without error reset");

endmodule // afc_axis_fault_checker

// ### logic/afc_pkg.sv
package afc_pkg;

  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned POS_W = 32;
  localparam int unsigned CODE_W = 16;

  // Absolute encoder answer window after a read request
  localparam int unsigned ABS_TIMEOUT_US = 1000;
  localparam int unsigned ABS_TIMEOUT_CYC = ABS_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned ABS_CNT_W = 17;

  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] CODE_CW_SOFT = 16'h0043;
  localparam logic [15:0] CODE_CCW_SOFT = 16'h0044;
  localparam logic [15:0] CODE_ORIGIN = 16'h0045;
  localparam logic [15:0] CODE_SERVO = 16'h0046;
  localparam logic [15:0] CODE_PRESET = 16'h0047;
  localparam logic [15:0] CODE_ESTOP = 16'h0048;
  localparam logic [15:0] CODE_ABS_LINK = 16'h0049;

  typedef enum logic [1:0] {
    STOP_NONE = 2'h0,
    STOP_DECEL = 2'h1,
    STOP_ACCUM = 2'h2,
    STOP_EMERG = 2'h3
  } afc_stop_t;

  typedef enum logic [2:0] {
    CMD_MOVE = 3'h0,
    CMD_MANUAL = 3'h1,
    CMD_COORD_SET = 3'h2,
    CMD_POS_CHANGE = 3'h3,
    CMD_PRESET = 3'h4
  } afc_cmd_t;

  typedef enum logic [1:0] {
    ST_CLEAR = 2'b01,
    ST_FAULT = 2'b10
  } afc_state_t;

endpackage

// ### logic/afc_abs_watch.sv
`timescale 1ns/100ps
module afc_abs_watch #(
  parameter int unsigned TIMEOUT_CYC = afc_pkg::ABS_TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic data_valid_i,
  input wire logic comm_err_i,
  output logic waiting_o,
  output logic fault_o
);

  typedef struct packed {
    logic waiting;
    logic [afc_pkg::ABS_CNT_W-1:0] cnt;
    logic fault;
  } afc_abs_t;

  afc_abs_t cur;
  afc_abs_t next_cur;

  always_comb
  begin
    next_cur = cur;
    next_cur.fault = 1'b0;
    if (cur.waiting)
    begin
      if (comm_err_i)
      begin
        // Corrupted transfer while receiving position data [RULE_11]
        next_cur.waiting = 1'b0;
        next_cur.fault = 1'b1;
      end
      else if (data_valid_i)
      begin
        next_cur.waiting = 1'b0;
      end
      else if (cur.cnt == afc_pkg::ABS_CNT_W'(TIMEOUT_CYC - 1))
      begin
        // Encoder never answered [RULE_10]
        next_cur.waiting = 1'b0;
        next_cur.fault = 1'b1;
      end
      else
      begin
        next_cur.cnt = cur.cnt + 1'b1;
      end
    end
    else if (req_i)
    begin
      next_cur.waiting = 1'b1;
      next_cur.cnt = '0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign waiting_o = cur.waiting;
  assign fault_o = cur.fault;

  chk_abs_comm_err: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_11]
    cur.waiting && comm_err_i |=> fault_o && !waiting_o)
    else $error("comm error while waiting did not raise link fault");

endmodule // afc_abs_watch

// ### tb/afc_enc_model.sv
`timescale 1ns/100ps
module afc_enc_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic [1:0] mode_i,
  input wire logic [31:0] pos_i,
  output logic valid_o,
  output logic err_o,
  output logic [31:0] pos_o
);
  // Mode 0 quick, 1 slow, 2 silent, 3 garbled answer
  logic [3:0] cnt;
  logic hit;
  assign hit = mode_i < 2'h2 && cnt == (mode_i[0] ? 4'h5 : 4'h2);
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt <= 4'h0;
      valid_o <= 1'b0;
      err_o <= 1'b0;
      pos_o <= 32'h0;
    end
    else
    begin
      cnt <= req_i ? 4'h1 : cnt + {3'h0, cnt != 4'h0};
      valid_o <= hit;
      err_o <= mode_i == 2'h3 && cnt == 4'h2;
      // Idle data toggles so a stale word never looks fresh
      pos_o <= hit ? pos_i : ~pos_o;
    end
  end
endmodule // afc_enc_model

// ### tb/afc_axis_fault_checker_bench.sv
`timescale 1ns/100ps
module afc_axis_fault_checker_bench;
  localparam logic [31:0] CW = 32'h3E8;
  localparam logic [31:0] CCW = 32'hFFFFFC18;
  localparam logic [31:0] PMAX = 32'h1388;
  localparam logic [31:0] PMIN = 32'hFFFFEC78;
  logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, mact = 1'b0, lock = 1'b0, absn = 1'b0;
  logic osd = 1'b0, est = 1'b0, sel = 1'b0, areq = 1'b0, erst = 1'b0;
  logic [2:0] kind = 3'h0;
  logic [31:0] val = 32'h0, apos = 32'h0, ap;
  logic [1:0] amode = 2'h0, meth;
  logic [15:0] code;
  logic flt, req, acc, rej, ook, wt, dv, ce;
  int failures = 0, samples_checked = 0;

  afc_axis_fault_checker #(.ABS_TIMEOUT_CYC(8)) i_dut (
    .MCLK_I(clk), .RST_N_I(rst_n), .CMD_VALID_I(vld), .CMD_KIND_I(kind),
    .CMD_VALUE_I(val), .CW_LIMIT_I(CW), .CCW_LIMIT_I(CCW), .PRESET_MIN_I(PMIN),
    .PRESET_MAX_I(PMAX), .MOTION_ACTIVE_I(mact), .SERVO_LOCK_I(lock),
    .ENC_ABSOLUTE_I(absn), .ORIGIN_SEARCH_DONE_I(osd), .ESTOP_I(est),
    .STOP_SEL_EMERG_I(sel), .ABS_REQ_I(areq), .ABS_DATA_VALID_I(dv),
    .ABS_POS_I(ap), .ABS_COMM_ERR_I(ce), .ERR_RESET_I(erst), .FAULT_O(flt),
    .FAULT_CODE_O(code), .STOP_METHOD_O(meth), .STOP_REQ_O(req),
    .CMD_ACCEPT_O(acc), .CMD_REJECT_O(rej), .ORIGIN_OK_O(ook), .ABS_WAIT_O(wt)
  );

  afc_enc_model i_enc (
    .clk_i(clk), .rst_n_i(rst_n), .req_i(areq), .mode_i(amode), .pos_i(apos),
    .valid_o(dv), .err_o(ce), .pos_o(ap)
  );

  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic final_report;
    if (failures == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic nx;
    @(negedge clk);
  endtask

  // One idle cycle ahead keeps the strobe from being reassigned in one step
  task automatic cmd(input logic [2:0] k, input logic [31:0] v);
    nx();
    vld = 1'b1;
    kind = k;
    val = v;
    nx();
    vld = 1'b0;
  endtask

  task automatic want(input logic [15:0] c, input logic [1:0] m, input logic r);
    chk(flt, c != 16'h0);
    chk(code, c);
    chk(meth, m);
    chk(req, c != 16'h0);
    chk(rej, r);
    chk(acc, c == 16'h0 && !r);
  endtask

  task automatic clr;
    nx();
    erst = 1'b1;
    nx();
    erst = 1'b0;
    chk(flt, 1'b0);
    chk(code, 16'h0);
  endtask

  task automatic t_limits;
    for (int a = 0; a < 2; a++)
    begin
      for (int k = 0; k < 5; k++)
      begin
        mact = a[0];
        cmd(k[2:0], CW);
        want(16'h0, 2'h0, 1'b0);
        cmd(k[2:0], CW + 32'h1);
        want(16'h0043, {a[0], !a[0]}, 1'b1);
        clr();
        cmd(k[2:0], CCW - 32'h1);
        want(16'h0044, {a[0], !a[0]}, 1'b1);
        clr();
      end
    end
    mact = 1'b0;
  endtask

  task automatic t_estop;
    for (int s = 0; s < 2; s++)
    begin
      sel = s[0];
      nx();
      est = 1'b1;
      nx();
      want(16'h0048, {1'b1, s[0]}, 1'b0);
      clr();
      cmd(3'h0, 32'h0);
      want(16'h0048, {1'b1, s[0]}, 1'b1);
      clr();
      est = 1'b0;
    end
  endtask

  // Error reset and a fresh fault in one cycle: the fresh fault must stand
  task automatic t_set_wins;
    cmd(3'h0, CW + 32'h1);
    want(16'h0043, 2'h1, 1'b1);
    nx();
    erst = 1'b1;
    vld = 1'b1;
    val = CCW - 32'h1;
    nx();
    erst = 1'b0;
    vld = 1'b0;
    want(16'h0044, 2'h1, 1'b1);
    clr();
  endtask

  task automatic absq(input logic [1:0] m, input logic [31:0] p, input logic [15:0] c);
    int n;
    amode = m;
    apos = p;
    nx();
    areq = 1'b1;
    nx();
    areq = 1'b0;
    chk(wt, 1'b1);
    n = 0;
    while (flt !== 1'b1 && n < 20)
    begin
      nx();
      n++;
    end
    chk(wt, 1'b0);
    if (c == 16'h0)
      chk(flt, 1'b0);
    else if (n == 20)
    begin
      failures++;
      final_report();
    end
    else
    begin
      want(c, 2'h1, 1'b0);
      clr();
    end
  endtask

  initial
  begin
    repeat (20) nx();
    rst_n = 1'b1;
    chk(flt, 1'b0);
    chk(ook, 1'b0);
    cmd(3'h1, 32'h0);
    want(16'h0046, 2'h1, 1'b1);
    repeat (3) nx();
    chk(code, 16'h0046);
    clr();
    lock = 1'b1;
    cmd(3'h0, 32'h0);
    want(16'h0045, 2'h1, 1'b1);
    clr();
    cmd(3'h4, 32'h0);
    want(16'h0, 2'h0, 1'b0);
    osd = 1'b1;
    nx();
    osd = 1'b0;
    chk(ook, 1'b1);
    t_limits();
    cmd(3'h4, PMAX + 32'h1);
    want(16'h0047, 2'h1, 1'b1);
    clr();
    cmd(3'h4, PMIN - 32'h1);
    want(16'h0047, 2'h1, 1'b1);
    clr();
    t_set_wins();
    t_estop();
    rst_n = 1'b0;
    lock = 1'b0;
    absn = 1'b1;
    nx();
    rst_n = 1'b1;
    chk(flt, 1'b0);
    chk(ook, 1'b0);
    nx();
    lock = 1'b1;
    nx();
    chk(ook, 1'b1);
    absq(2'h2, 32'h0, 16'h0049);
    absq(2'h3, 32'h0, 16'h0049);
    absq(2'h0, CW + 32'h1, 16'h0043);
    absq(2'h1, 32'h0, 16'h0);
    final_report();
  end
endmodule // afc_axis_fault_checker_bench
